// >>> hss_map.svh
// Constants of the high-side switch serial port and undervoltage logic
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH

// ----------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------
`define HSS_WORD_W      8
`define HSS_ADDR_HI     7
`define HSS_ADDR_LO     4
`define HSS_REG_HI      6
`define HSS_FRAME_MOD   3
`define HSS_REG_STAT    3'h0
`define HSS_REG_OCR     3'h1
`define HSS_ADDR_UOVR   4'he

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HSS_OCR_IN0     0
`define HSS_OCR_IN1     2
`define HSS_UOVR_UV     1
`define HSS_UOVR_OV     0
`define HSS_FLT_UV      4
`define HSS_FLT_FS      3

// ----------------------------------------------------------------
// Readout selections (D7 and D2:D0 of a status request)
// ----------------------------------------------------------------
`define HSS_SEL_FAULT   4'h0
`define HSS_SEL_OCR     4'h1
`define HSS_SEL_UOVR    4'h6
`define HSS_SEL_INPUTS  4'h7

// ----------------------------------------------------------------
// Synchroniser lanes
// ----------------------------------------------------------------
`define HSS_SYNC_N      8
`define HSS_S_CS        0
`define HSS_S_IN0       1
`define HSS_S_IN1       2
`define HSS_S_GND       3
`define HSS_S_UVTH      4
`define HSS_S_POR       5
`define HSS_S_MIN       6
`define HSS_S_VDD       7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSS_RST_SYNC    8'h01
`define HSS_RST_OCR     4'h0
`define HSS_RST_SEL     4'h0
`define HSS_RST_TX      8'h00

`endif

// >>> hss_pkg.sv
// Types of the high-side switch serial port and undervoltage logic
package hss_pkg;

	// ------------------------------------------------------------
	// Core state, system clock domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic       cs_d;
		logic [7:0] start_cnt;
		logic [7:0] tx_hold;
		logic [3:0] ocr;
		logic       uv_off;
		logic       ov_off;
		logic [3:0] sel;
		logic [1:0] latch;
		logic       flag;
		logic       fs;
		logic [1:0] hs;
	} hss_state_t;

	// ------------------------------------------------------------
	// Link state, serial clock domain
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] sh;
		logic [7:0] cnt;
	} hss_rx_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic       so;
	} hss_tx_t;

endpackage : hss_pkg

// >>> hss_spi_link.sv
// Serial shifter on the master's clock
`timescale 1ns/1ps
`include "hss_map.svh"

module hss_spi_link
	import hss_pkg::*;
(
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       si,
	input  wire logic       rst_n,
	input  wire logic [7:0] tx_word,
	output logic      [7:0] rx_word,
	output logic      [7:0] fall_cnt,
	output logic            so_out,
	output logic            so_oe_n
);

	hss_rx_t rx_r;
	hss_rx_t rx_nxt;
	hss_tx_t tx_r;
	hss_tx_t tx_nxt;
	logic    tx_arst_n;
	logic [2:0] tx_idx;

	// ------------------------------------------------------------
	// Receive side, falling edges
	// ------------------------------------------------------------
	// Capture MSB first, count every falling edge of the frame
	always_comb
	begin
		rx_nxt = rx_r;
		if (!cs_n)
		begin
			rx_nxt.sh  = {rx_r.sh[6:0], si};
			rx_nxt.cnt = rx_r.cnt + 8'h01;
		end
	end

	// Register receive state
	always_ff @(negedge sclk or negedge rst_n)
	begin
		if (!rst_n)
			rx_r <= '0;
		else
			rx_r <= rx_nxt;
	end

	// ------------------------------------------------------------
	// Transmit side, rising edges
	// ------------------------------------------------------------
	// Held off while chip select is high
	assign tx_arst_n = rst_n & ~cs_n;
	assign tx_idx    = 3'(4'h7 - tx_r.cnt); // Rise k launches bit 8-k

	// Status word first, then the bits taken in eight edges before
	always_comb
	begin
		tx_nxt = tx_r;
		if (tx_r.cnt != 4'h8)
			tx_nxt.cnt = tx_r.cnt + 4'h1;
		if (tx_r.cnt >= 4'h8)
			tx_nxt.so = rx_r.sh[7];
		else
			tx_nxt.so = tx_word[tx_idx];
	end

	// Register transmit state
	always_ff @(posedge sclk or negedge tx_arst_n)
	begin
		if (!tx_arst_n)
			tx_r <= '0;
		else
			tx_r <= tx_nxt;
	end

	// MSB stands before the first rising edge
	assign so_out   = (tx_r.cnt == 4'h0) ? tx_word[7] : tx_r.so;
	assign so_oe_n  = cs_n;
	assign rx_word  = rx_r.sh;
	assign fall_cnt = rx_r.cnt;

endmodule : hss_spi_link

// >>> hss_ctrl.sv
// Serial control port and undervoltage logic of a dual high-side switch
`timescale 1ns/1ps
`include "hss_map.svh"

module hss_ctrl
	import hss_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic in0_pin,
	input  wire logic in1_pin,
	input  wire logic gnd_lost,
	input  wire logic below_uv_threshold,
	input  wire logic below_por_level,
	input  wire logic below_min_supply,
	input  wire logic logic_supply_ok,
	output logic      so_out,
	output logic      so_oe_n,
	output logic      hs0_on,
	output logic      hs1_on,
	output logic      fault_status_pin,
	output logic      undervoltage_flag,
	output logic      undervoltage_protect_off
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rel_r;
	logic       rst_n;

	// Release through two flops, assert at once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rel_r <= 2'h0;
		else
			rel_r <= {rel_r[0], 1'b1};
	end

	assign rst_n = rel_r[1];

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hss_state_t r;
	hss_state_t n;
	logic [7:0] rx_word;
	logic [7:0] fall_cnt;
	logic [7:0] frame_bits;
	logic [7:0] status_word;
	logic [1:0] pin_in;
	logic [1:0] spi_in;
	logic [1:0] cmd;
	logic [1:0] latch_nxt;
	logic [1:0] out_nxt;
	logic       cs_s;
	logic       cs_fall;
	logic       cs_rise;
	logic       frame_ok;
	logic       stat_read;
	logic       gnd_s;
	logic       uvth_s;
	logic       por_s;
	logic       min_s;
	logic       vdd_s;
	logic       uv_on;
	logic       uv_set;
	logic       fs_low;

	// ------------------------------------------------------------
	// Serial link on the master's clock
	// ------------------------------------------------------------
	hss_spi_link u_link (
		.sclk     (sclk),
		.cs_n     (cs_n),
		.si       (si),
		.rst_n    (rst_n),
		.tx_word  (r.tx_hold),
		.rx_word  (rx_word),
		.fall_cnt (fall_cnt),
		.so_out   (so_out),
		.so_oe_n  (so_oe_n)
	);

	// ------------------------------------------------------------
	// Synchronised pins and frame edges
	// ------------------------------------------------------------
	assign cs_s    = r.sync2[`HSS_S_CS];
	assign gnd_s   = r.sync2[`HSS_S_GND];
	assign uvth_s  = r.sync2[`HSS_S_UVTH];
	assign por_s   = r.sync2[`HSS_S_POR];
	assign min_s   = r.sync2[`HSS_S_MIN];
	assign vdd_s   = r.sync2[`HSS_S_VDD];
	assign cs_fall = r.cs_d & ~cs_s;
	assign cs_rise = ~r.cs_d & cs_s;

	// Whole words only; link counters stand still while deselected
	assign frame_bits = fall_cnt - r.start_cnt;
	assign frame_ok   = cs_rise && (frame_bits != 8'h00)
		&& (frame_bits[`HSS_FRAME_MOD-1:0] == 3'h0);
	assign stat_read  = frame_ok && (r.sel == `HSS_SEL_FAULT);

	// ------------------------------------------------------------
	// Undervoltage qualifiers
	// ------------------------------------------------------------
	assign uv_on  = vdd_s & ~r.uv_off;
	assign uv_set = uv_on & (uvth_s | (|r.latch));
	assign fs_low = uv_on & ~por_s & (uvth_s | (|r.latch));

	// ------------------------------------------------------------
	// Per-channel command and output
	// ------------------------------------------------------------
	assign pin_in = {r.sync2[`HSS_S_IN1], r.sync2[`HSS_S_IN0]};
	assign spi_in = {r.ocr[`HSS_OCR_IN1], r.ocr[`HSS_OCR_IN0]};

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_ch
		// Either source asks for on
		assign cmd[ch] = pin_in[ch] | spi_in[ch];
		// Armed under threshold, held until command drops
		assign latch_nxt[ch] = uv_on & cmd[ch] & (uvth_s | r.latch[ch]);
		// Ground loss, low supply or latch kill the output
		assign out_nxt[ch] = cmd[ch] & ~gnd_s & ~min_s
			& ~(uv_on & (uvth_s | r.latch[ch]));
	end

	// ------------------------------------------------------------
	// Readout word
	// ------------------------------------------------------------
	// Content picked by the last status request
	always_comb
	begin
		status_word = 8'h00;
		case (r.sel)
			`HSS_SEL_FAULT:
			begin
				status_word[`HSS_FLT_UV] = r.flag;
				status_word[`HSS_FLT_FS] = ~r.fs;
				status_word[1:0]         = r.hs;
			end
			`HSS_SEL_OCR:    status_word = {4'h0, r.ocr};
			`HSS_SEL_UOVR:   status_word = {6'h00, r.uv_off, r.ov_off};
			`HSS_SEL_INPUTS: status_word = {6'h00, pin_in};
			default:         status_word = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.sync1 = {logic_supply_ok, below_min_supply, below_por_level,
			below_uv_threshold, gnd_lost, in1_pin, in0_pin, cs_n};
		n.sync2 = r.sync1;
		n.cs_d  = cs_s;

		// Snapshot counter and status at frame start
		if (cs_fall)
		begin
			n.start_cnt = fall_cnt;
			n.tx_hold   = status_word;
		end

		// Latch the last whole word at frame end
		if (frame_ok)
		begin
			if (rx_word[`HSS_ADDR_HI:`HSS_ADDR_LO] == `HSS_ADDR_UOVR)
			begin
				n.uv_off = rx_word[`HSS_UOVR_UV];
				n.ov_off = rx_word[`HSS_UOVR_OV];
			end
			else if (rx_word[`HSS_REG_HI:`HSS_ADDR_LO] == `HSS_REG_OCR)
				n.ocr = rx_word[3:0];
			else if (rx_word[`HSS_REG_HI:`HSS_ADDR_LO] == `HSS_REG_STAT)
				n.sel = {rx_word[`HSS_ADDR_HI], rx_word[2:0]};
		end

		// Undervoltage latch, flag and fault pin
		n.latch = latch_nxt;
		n.flag  = uv_on & (uv_set | (r.flag & ~stat_read));
		n.fs    = ~fs_low;
		n.hs    = out_nxt;

		// Serial settings lost without logic supply
		if (!vdd_s)
		begin
			n.ocr    = `HSS_RST_OCR;
			n.uv_off = 1'b0;
			n.ov_off = 1'b0;
			n.sel    = `HSS_RST_SEL;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r           <= '0;
			r.sync1     <= `HSS_RST_SYNC;
			r.sync2     <= `HSS_RST_SYNC;
			r.cs_d      <= 1'b1;
			r.tx_hold   <= `HSS_RST_TX;
			r.ocr       <= `HSS_RST_OCR;
			r.sel       <= `HSS_RST_SEL;
			r.fs        <= 1'b1;
		end
		else
			r <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hs0_on                   = r.hs[0];
	assign hs1_on                   = r.hs[1];
	assign fault_status_pin         = r.fs;
	assign undervoltage_flag        = r.flag;
	assign undervoltage_protect_off = r.uv_off;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_gnd_off;
		@(posedge clk) disable iff (!rst_n)
		gnd_s |=> (r.hs == 2'h0);
	endproperty
	a_gnd_off: assert property (p_gnd_off)
		else $error("output on after ground loss");

	property p_uv_band;
		@(posedge clk) disable iff (!rst_n)
		(uv_on && uvth_s && !por_s) |=> (!r.fs && r.flag && (r.hs == 2'h0));
	endproperty
	a_uv_band: assert property (p_uv_band)
		else $error("undervoltage band not reported");

	property p_por_band;
		@(posedge clk) disable iff (!rst_n)
		(uv_on && por_s) |=> (r.fs && r.flag && (r.hs == 2'h0));
	endproperty
	a_por_band: assert property (p_por_band)
		else $error("fault pin low below reset level");

	property p_recover_off;
		@(posedge clk) disable iff (!rst_n)
		($fell(uvth_s) && uv_on && (cmd == 2'h0) && (r.latch == 2'h0))
			|=> (r.fs && (r.hs == 2'h0));
	endproperty
	a_recover_off: assert property (p_recover_off)
		else $error("recovery with command off misbehaves");

	property p_latched;
		@(posedge clk) disable iff (!rst_n)
		(uv_on && r.latch[0] && cmd[0] && !por_s)
			|=> (!r.hs[0] && !r.fs && r.flag);
	endproperty
	a_latched: assert property (p_latched)
		else $error("latched channel came back on");

	property p_uv_disabled;
		@(posedge clk) disable iff (!rst_n)
		(r.uv_off && $stable(r.uv_off)) |=> (r.fs && !r.flag);
	endproperty
	a_uv_disabled: assert property (p_uv_disabled)
		else $error("undervoltage reported while disabled");

	property p_min_supply;
		@(posedge clk) disable iff (!rst_n)
		min_s |=> (r.hs == 2'h0);
	endproperty
	a_min_supply: assert property (p_min_supply)
		else $error("output on below minimum supply");

	property p_no_logic;
		@(posedge clk) disable iff (!rst_n)
		!vdd_s |=> (!r.uv_off && (r.ocr == `HSS_RST_OCR) && !r.flag);
	endproperty
	a_no_logic: assert property (p_no_logic)
		else $error("settings kept without logic supply");

	property p_either_cmd;
		@(posedge clk) disable iff (!rst_n)
		(!uv_on && !gnd_s && !min_s && (pin_in[1] || spi_in[1])) |=> r.hs[1];
	endproperty
	a_either_cmd: assert property (p_either_cmd)
		else $error("command source ignored");

	property p_status_load;
		@(posedge clk) disable iff (!rst_n)
		cs_fall |=> (r.tx_hold == $past(status_word));
	endproperty
	a_status_load: assert property (p_status_load)
		else $error("status not loaded at frame start");

	property p_read_clear;
		@(posedge clk) disable iff (!rst_n)
		(stat_read && !uv_set) |=> !r.flag;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("flag survived status read");

	property p_set_wins;
		@(posedge clk) disable iff (!rst_n)
		(stat_read && uv_set) |=> r.flag ##1 (r.flag || !uv_set);
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("flag lost while condition stands");

endmodule : hss_ctrl

// >>> hss_host.sv
// SPI master model for the switch serial port
`timescale 1ns/1ps

module hss_host
(
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	initial
	begin
		sclk = 1'b0; // Clock low while idle
		cs_n = 1'b1;
		si = 1'b0;
	end

	// ----------------------------------------
	// One frame of nb bits, full duplex
	// ----------------------------------------
	task automatic xfer_n(input int nb, input logic [15:0] cmd, output logic [15:0] rd);
		rd = '0;
		cs_n = 1'b0; // Clock low at select fall
		#503;
		for (int i = nb - 1; i >= 0; i--)
		begin
			si = cmd[i]; // MSB first
			#8 sclk = 1'b1;
			#16 rd[i] = so; // Sampled at the fall
			sclk = 1'b0;
			#8;
		end
		#8 cs_n = 1'b1; // Clock low at select rise
		si = ~si; // Released line loses its last level
		#500;
	endtask : xfer_n

	// Single 8-bit word
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] rd);
		logic [15:0] w;
		xfer_n(8, {8'h00, cmd}, w);
		rd = w[7:0];
	endtask : xfer

	// ----------------------------------------
	// Clock and data activity while deselected
	// ----------------------------------------
	task automatic noise(input logic [7:0] pat);
		for (int i = 7; i >= 0; i--)
		begin
			si = pat[i];
			#16 sclk = 1'b1;
			#16 sclk = 1'b0;
		end
	endtask : noise
endmodule : hss_host

// >>> testbench.sv
// Self-checking bench of the switch serial port and undervoltage logic
`timescale 1ns/1ps

module testbench;
	logic       clk;
	logic       reset_n;
	logic       in0_pin;
	logic       in1_pin;
	logic       gnd_lost;
	logic       below_uv_threshold;
	logic       below_por_level;
	logic       below_min_supply;
	logic       logic_supply_ok;
	logic       so_out;
	logic       so_oe_n;
	logic       hs0_on;
	logic       hs1_on;
	logic       fault_status_pin;
	logic       undervoltage_flag;
	logic       undervoltage_protect_off;
	logic       sclk;
	logic       cs_n;
	logic       si;
	logic       so_keep;
	logic       so_line;
	logic [7:0] rd;
	int         miscompares;
	int         n_checks;

	// ----------------------------------------
	// Design, master model, data line
	// ----------------------------------------
	hss_ctrl u_hss_ctrl (.clk, .reset_n, .sclk, .cs_n, .si, .in0_pin, .in1_pin,
		.gnd_lost, .below_uv_threshold, .below_por_level, .below_min_supply,
		.logic_supply_ok, .so_out, .so_oe_n, .hs0_on, .hs1_on, .fault_status_pin,
		.undervoltage_flag, .undervoltage_protect_off);
	hss_host u_hss_host (.sclk, .cs_n, .si, .so(so_line));

	// Released data line shows inverse of last driven bit
	always @(so_out or so_oe_n)
		if (!so_oe_n)
			so_keep = so_out;
	assign so_line = so_oe_n ? ~so_keep : so_out;

	// System clock
	always #50 clk = ~clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [7:0] st();
		return {3'h0, undervoltage_protect_off, hs1_on, hs0_on, fault_status_pin,
			undervoltage_flag};
	endfunction : st

	task automatic wt();
		repeat (8) @(negedge clk);
	endtask : wt

	task automatic cmd(input logic [7:0] c);
		@(negedge clk);
		u_hss_host.xfer(c, rd);
		wt();
	endtask : cmd

	// Supply bands, nested min, por, threshold
	task automatic sup(input logic [2:0] v);
		@(negedge clk);
		{below_min_supply, below_por_level, below_uv_threshold} = v;
		wt();
	endtask : sup

	task automatic test_done();
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_serial();
		check({7'h0, so_oe_n}, 8'h01);
		check(st(), 8'h02);
		cmd(8'h15);
		check(st(), 8'h0e);
		cmd(8'h01);
		cmd(8'h00);
		check(rd, 8'h05);
		cmd(8'h10);
		check(rd, 8'h03);
		check(st(), 8'h02);
		u_hss_host.noise(8'h15);
		check({7'h0, so_oe_n}, 8'h01);
		wt();
		check(st(), 8'h02);
		in0_pin = 1'b1;
		wt();
		check(st(), 8'h06);
		in0_pin = 1'b0;
		wt();
	endtask : t_serial

	task automatic t_uv_on();
		cmd(8'h15);
		sup(3'b001);
		check(st(), 8'h01);
		cmd(8'h00);
		check(rd, 8'h18);
		check(st(), 8'h01);
		sup(3'b011);
		check(st(), 8'h03);
		sup(3'b001);
		sup(3'b000);
		check(st(), 8'h01);
		cmd(8'h10);
		check(st(), 8'h03);
		cmd(8'h00);
		check(rd, 8'h10);
		check(st(), 8'h02);
		cmd(8'h15);
		check(st(), 8'h0e);
	endtask : t_uv_on

	task automatic t_uv_off();
		cmd(8'h10);
		sup(3'b001);
		check(st(), 8'h01);
		sup(3'b000);
		check(st(), 8'h03);
		cmd(8'h00);
		check(st(), 8'h02);
		cmd(8'h15);
		sup(3'b111);
		check(st(), 8'h03);
		sup(3'b000);
		cmd(8'h10);
		cmd(8'h00);
		check(st(), 8'h02);
	endtask : t_uv_off

	task automatic t_dis();
		cmd(8'he2);
		cmd(8'h06);
		cmd(8'h00);
		check(rd, 8'h02);
		cmd(8'h15);
		sup(3'b011);
		check(st(), 8'h1e);
		sup(3'b111);
		check(st(), 8'h12);
		sup(3'b000);
		cmd(8'he0);
		check(st(), 8'h0e);
		gnd_lost = 1'b1;
		wt();
		check(st(), 8'h02);
		gnd_lost = 1'b0;
		wt();
		check(st(), 8'h0e);
	endtask : t_dis

	task automatic t_lsup();
		in0_pin = 1'b1;
		logic_supply_ok = 1'b0;
		sup(3'b001);
		check(st(), 8'h06);
		sup(3'b000);
		logic_supply_ok = 1'b1;
		in0_pin = 1'b0;
		wt();
		check(st(), 8'h02);
	endtask : t_lsup

	// Two-word frame echoes first word; short frame refused
	task automatic t_frames();
		logic [15:0] w;
		@(negedge clk);
		u_hss_host.xfer_n(16, 16'h1015, w);
		wt();
		check(w[15:8], 8'h00);
		check(w[7:0], 8'h10);
		check(st(), 8'h0e);
		@(negedge clk);
		u_hss_host.xfer_n(7, 16'h0010, w);
		wt();
		check(st(), 8'h0e);
		cmd(8'h10);
		check(st(), 8'h02);
	endtask : t_frames

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		{in0_pin, in1_pin, gnd_lost, below_uv_threshold} = '0;
		{below_por_level, below_min_supply} = '0;
		logic_supply_ok = 1'b1;
		miscompares = 0;
		n_checks = 0;
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		wt();
		t_serial();
		t_uv_on();
		t_uv_off();
		t_dis();
		t_lsup();
		t_frames();
		test_done();
	end

	initial
	begin
		#2000000;
		miscompares++;
		test_done();
	end
endmodule : testbench
